/* hw/exio_port.v */
// extended 64-point i/o port with apb register access
//
// How it works
// - 64 points 17-80, eight groups, shared direction
// - mask bit one makes group outputs
// - mask bit 0 is group 2, ascending
// - save stores mask and outputs; default inputs
// - set and clear single output points 1-8, 17-80
// - single point driven from conditional value
// - group write: 8-bit main, four 16-bit fields
// - group write ignores bits of input groups
// - supplied fields replace fully, omitted untouched
// - group read of group 0 or 2-9
// - point query; 17 is group 2 bit 0
// - query returns one high, zero low
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "exio_defs.vh"

module exio_port (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        por_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  input  wire [7:0]  main_in,
  output wire [7:0]  main_out,
  input  wire [63:0] ext_in,
  output wire [63:0] ext_out,
  output wire [63:0] ext_oe
);

  reg  [7:0]  dir_q;
  reg  [7:0]  main_q;
  reg  [63:0] out_q;
  reg  [7:0]  main_d;
  reg  [63:0] out_d;
  reg  [7:0]  fld_m_q;
  reg  [63:0] fld_ext_q;
  reg  [3:0]  grp_sel_q;
  reg  [7:0]  pt_sel_q;
  reg         cmd_err_q;
  reg         cmd_err_d;
  reg         load_pend_q;
  reg         rd_stale_q;
  integer     int_i;
  reg  [31:0] rd_d;
  reg         map_hit;
  reg  [7:0]  grp_lvl;
  reg         bit_val;
  reg         pt_lvl;

  wire        setup_ph;
  wire        wr_acc;
  wire        wr_dir;
  wire        wr_cmd;
  wire        wr_go;
  wire        wr_save;
  wire        wr_stat;
  wire [7:0]  cmd_pt;
  wire [1:0]  cmd_kind;
  wire        cmd_val;
  wire        c_main;
  wire        c_ext;
  wire [2:0]  c_main_idx;
  wire [5:0]  c_ext_idx;
  wire        q_main;
  wire        q_ext;
  wire [2:0]  q_main_idx;
  wire [5:0]  q_ext_idx;
  wire [7:0]  grp_apply;
  wire        nv_valid;
  wire [7:0]  nv_dir;
  wire [7:0]  nv_main;
  wire [63:0] nv_out;
  wire [2:0]  ext_grp_idx;

  // bus held off for the image-load cycle after reset, and once more
  // when a setup landed in it, so read data shows the loaded image
  assign pready   = ~load_pend_q & ~rd_stale_q;
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite & pready;
  assign wr_dir   = wr_acc && (paddr == `EXIO_A_DIR);
  assign wr_cmd   = wr_acc && (paddr == `EXIO_A_CMD);
  assign wr_go    = wr_acc && (paddr == `EXIO_A_GRP_GO);
  assign wr_save  = wr_acc && (paddr == `EXIO_A_SAVE) && pwdata[0];
  assign wr_stat  = wr_acc && (paddr == `EXIO_A_STATUS);

  // point command word: point, kind, conditional value
  assign cmd_pt   = pwdata[`EXIO_CMD_PT_LSB +: 8];
  assign cmd_kind = pwdata[`EXIO_CMD_KIND_LSB +: 2];
  assign cmd_val  = pwdata[`EXIO_CMD_VAL_BIT];

  exio_point_dec u_cmd_dec (
    .point    (cmd_pt),
    .is_main  (c_main),
    .is_ext   (c_ext),
    .main_idx (c_main_idx),
    .ext_idx  (c_ext_idx)
  );

  exio_point_dec u_qry_dec (
    .point    (pt_sel_q),
    .is_main  (q_main),
    .is_ext   (q_ext),
    .main_idx (q_main_idx),
    .ext_idx  (q_ext_idx)
  );

  exio_nv_store u_nv (
    .pclk    (pclk),
    .por_n   (por_n),
    .save    (wr_save),
    .dir_in  (dir_q),
    .main_in (main_q),
    .out_in  (out_q),
    .valid_q (nv_valid),
    .dir_q   (nv_dir),
    .main_q  (nv_main),
    .out_q   (nv_out)
  );

  // per group: direction drives enables, group write gated by mask
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_grp
      assign ext_oe[g*8 +: 8] = {8{dir_q[g]}};
      assign grp_apply[g]     = wr_go & pwdata[1 + g/2] & dir_q[g];
    end
  endgenerate

  // input groups keep their stored state, only the enable drops
  assign ext_out     = out_q;
  assign main_out    = main_q;
  assign ext_grp_idx = c_ext_idx[5:3];

  // next output state from group writes and point commands
  always @*
  begin
    main_d    = main_q;
    out_d     = out_q;
    cmd_err_d = cmd_err_q;
    bit_val   = 1'b0;
    case (cmd_kind)
      `EXIO_KIND_SET:  bit_val = 1'b1;
      `EXIO_KIND_CLR:  bit_val = 1'b0;
      `EXIO_KIND_COND: bit_val = cmd_val;
      default:         bit_val = 1'b0;
    endcase
    if (wr_stat && pwdata[`EXIO_ST_CMD_ERR])
      cmd_err_d = 1'b0;
    if (wr_go && pwdata[0])
      main_d = fld_m_q;
    for (int_i = 0; int_i < 8; int_i = int_i + 1)
    begin
      if (grp_apply[int_i])
        out_d[int_i*8 +: 8] = fld_ext_q[int_i*8 +: 8];
    end
    // kind 3, unknown points and input-group points only flag an error
    if (wr_cmd)
    begin
      if (cmd_kind == 2'h3)
        cmd_err_d = 1'b1;
      else if (c_main)
        main_d[c_main_idx] = bit_val;
      else if (c_ext && dir_q[ext_grp_idx])
        out_d[c_ext_idx] = bit_val;
      else
        cmd_err_d = 1'b1;
    end
  end

  // output, direction and staging state
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_q       <= `EXIO_DIR_RST;
      main_q      <= `EXIO_MAIN_RST;
      out_q       <= `EXIO_OUT_RST;
      fld_m_q     <= 8'h00;
      fld_ext_q   <= 64'h0000000000000000;
      grp_sel_q   <= 4'h0;
      pt_sel_q    <= 8'h00;
      cmd_err_q   <= 1'b0;
      load_pend_q <= 1'b1;
    end
    else if (load_pend_q)
    begin
      // image is all zero when nothing was ever saved
      dir_q       <= nv_dir;
      main_q      <= nv_main;
      out_q       <= nv_out;
      load_pend_q <= 1'b0;
    end
    else
    begin
      main_q    <= main_d;
      out_q     <= out_d;
      cmd_err_q <= cmd_err_d;
      if (wr_dir)
        dir_q <= pwdata[7:0];
      if (wr_acc && (paddr == `EXIO_A_MAIN))
        fld_m_q <= pwdata[7:0];
      if (wr_acc && (paddr == `EXIO_A_FLD_A))
        fld_ext_q[15:0] <= pwdata[15:0];
      if (wr_acc && (paddr == `EXIO_A_FLD_B))
        fld_ext_q[31:16] <= pwdata[15:0];
      if (wr_acc && (paddr == `EXIO_A_FLD_C))
        fld_ext_q[47:32] <= pwdata[15:0];
      if (wr_acc && (paddr == `EXIO_A_FLD_D))
        fld_ext_q[63:48] <= pwdata[15:0];
      if (wr_acc && (paddr == `EXIO_A_GRP_SEL))
        grp_sel_q <= pwdata[3:0];
      if (wr_acc && (paddr == `EXIO_A_PT_SEL))
        pt_sel_q <= pwdata[7:0];
    end
  end

  // level of the selected group, pin levels
  always @*
  begin
    grp_lvl = 8'h00;
    case (grp_sel_q)
      `EXIO_GRP_MAIN: grp_lvl = main_in;
      4'h2:           grp_lvl = ext_in[7:0];
      4'h3:           grp_lvl = ext_in[15:8];
      4'h4:           grp_lvl = ext_in[23:16];
      4'h5:           grp_lvl = ext_in[31:24];
      4'h6:           grp_lvl = ext_in[39:32];
      4'h7:           grp_lvl = ext_in[47:40];
      4'h8:           grp_lvl = ext_in[55:48];
      4'h9:           grp_lvl = ext_in[63:56];
      default:        grp_lvl = 8'h00;
    endcase
  end

  // level of the selected single point
  always @*
  begin
    pt_lvl = 1'b0;
    if (q_main)
      pt_lvl = main_in[q_main_idx];
    else if (q_ext)
      pt_lvl = ext_in[q_ext_idx];
  end

  // read mux, latched in the setup cycle
  always @*
  begin
    rd_d    = 32'h00000000;
    map_hit = 1'b1;
    case (paddr)
      `EXIO_A_DIR:     rd_d = {24'h000000, dir_q};
      `EXIO_A_CMD:     rd_d = 32'h00000000;
      `EXIO_A_MAIN:    rd_d = {24'h000000, main_q};
      `EXIO_A_FLD_A:   rd_d = {16'h0000, out_q[15:0]};
      `EXIO_A_FLD_B:   rd_d = {16'h0000, out_q[31:16]};
      `EXIO_A_FLD_C:   rd_d = {16'h0000, out_q[47:32]};
      `EXIO_A_FLD_D:   rd_d = {16'h0000, out_q[63:48]};
      `EXIO_A_GRP_GO:  rd_d = 32'h00000000;
      `EXIO_A_SAVE:    rd_d = 32'h00000000;
      `EXIO_A_GRP_SEL: rd_d = {28'h0000000, grp_sel_q};
      `EXIO_A_GRP_LVL: rd_d = {24'h000000, grp_lvl};
      `EXIO_A_PT_SEL:  rd_d = {15'h0000, pt_lvl, 8'h00, pt_sel_q};
      `EXIO_A_STATUS:  rd_d = {30'h00000000, cmd_err_q, nv_valid};
      default:
      begin
        rd_d    = 32'h00000000;
        map_hit = 1'b0;
      end
    endcase
  end

  // a setup seen in the image-load cycle read pre-load state; sample again
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata     <= 32'h00000000;
      pslverr    <= 1'b0;
      rd_stale_q <= 1'b0;
    end
    else
    begin
      rd_stale_q <= setup_ph & load_pend_q;
      if (setup_ph | rd_stale_q)
      begin
        prdata  <= pwrite ? 32'h00000000 : rd_d;
        pslverr <= ~map_hit;
      end
    end
  end

endmodule // exio_port

/* hw/exio_defs.vh */
// register map, field positions and reset values of the extended i/o port
`ifndef EXIO_DEFS_VH
`define EXIO_DEFS_VH

// apb byte addresses
`define EXIO_A_DIR      8'h00
`define EXIO_A_CMD      8'h04
`define EXIO_A_MAIN     8'h08
`define EXIO_A_FLD_A    8'h0C
`define EXIO_A_FLD_B    8'h10
`define EXIO_A_FLD_C    8'h14
`define EXIO_A_FLD_D    8'h18
`define EXIO_A_GRP_GO   8'h1C
`define EXIO_A_SAVE     8'h20
`define EXIO_A_GRP_SEL  8'h24
`define EXIO_A_GRP_LVL  8'h28
`define EXIO_A_PT_SEL   8'h2C
`define EXIO_A_STATUS   8'h30

// point command register fields
`define EXIO_CMD_PT_LSB   0
`define EXIO_CMD_KIND_LSB 8
`define EXIO_CMD_VAL_BIT  16

// point command kinds
`define EXIO_KIND_SET   2'h0
`define EXIO_KIND_CLR   2'h1
`define EXIO_KIND_COND  2'h2

// status register bits
`define EXIO_ST_NV_VALID 0
`define EXIO_ST_CMD_ERR  1

// point numbering
`define EXIO_PT_MAIN_LO 8'h01
`define EXIO_PT_MAIN_HI 8'h08
`define EXIO_PT_EXT_LO  8'h11
`define EXIO_PT_EXT_HI  8'h50

// group numbering for group reads
`define EXIO_GRP_MAIN   4'h0
`define EXIO_GRP_EXT_LO 4'h2
`define EXIO_GRP_EXT_HI 4'h9

// reset values
`define EXIO_DIR_RST    8'h00
`define EXIO_OUT_RST    64'h0000000000000000
`define EXIO_MAIN_RST   8'h00

`endif

/* hw/exio_point_dec.v */
// decodes a point number into main or extended bit index
`timescale 1ns/10ps
`include "exio_defs.vh"

module exio_point_dec (
  input  wire [7:0] point,
  output wire       is_main,
  output wire       is_ext,
  output wire [2:0] main_idx,
  output wire [5:0] ext_idx
);

  wire [7:0] main_off;
  wire [7:0] ext_off;

  assign main_off = point - `EXIO_PT_MAIN_LO;
  assign ext_off  = point - `EXIO_PT_EXT_LO;
  assign is_main  = (point >= `EXIO_PT_MAIN_LO) && (point <= `EXIO_PT_MAIN_HI);
  assign is_ext   = (point >= `EXIO_PT_EXT_LO) && (point <= `EXIO_PT_EXT_HI);
  assign main_idx = main_off[2:0];
  // point 17 lands on bit 0 of group 2
  assign ext_idx  = ext_off[5:0];

endmodule // exio_point_dec

/* hw/exio_nv_store.v */
// nonvolatile image of direction mask and output states
`timescale 1ns/10ps
`include "exio_defs.vh"

module exio_nv_store (
  input  wire        pclk,
  input  wire        por_n,
  input  wire        save,
  input  wire [7:0]  dir_in,
  input  wire [7:0]  main_in,
  input  wire [63:0] out_in,
  output reg         valid_q,
  output reg  [7:0]  dir_q,
  output reg  [7:0]  main_q,
  output reg  [63:0] out_q
);

  // only power-on clears the image; the bus reset leaves it alone
  always @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      valid_q <= 1'b0;
      dir_q   <= `EXIO_DIR_RST;
      main_q  <= `EXIO_MAIN_RST;
      out_q   <= `EXIO_OUT_RST;
    end
    else if (save)
    begin
      valid_q <= 1'b1;
      dir_q   <= dir_in;
      main_q  <= main_in;
      out_q   <= out_in;
    end
  end

endmodule // exio_nv_store

/* test/exio_port_props.sv */
// assertions on the extended i/o port outputs
`timescale 1ns/10ps
module exio_port_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire        pready,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pslverr,
  input wire [7:0]  main_out,
  input wire [63:0] ext_out,
  input wire [63:0] ext_oe
);
  wire [7:0]   pt = pwdata[7:0];
  wire [1:0]   kd = pwdata[9:8];
  wire         wr = psel & penable & pwrite & pready;
  wire         cmd = wr & (paddr == 8'h04) & (kd != 2'h3);
  wire         bv = (kd == 2'h2) ? pwdata[16] : ~kd[0];
  wire         is_x = (pt >= 8'h11) & (pt <= 8'h50);
  wire [5:0]   xi = pt[5:0] - 6'h11;
  logic [63:0] dir_x;
  always_comb
    for (int g = 0; g < 8; g++)
      dir_x[8*g +: 8] = {8{pwdata[g]}};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_oe_write: assert property (wr && paddr == 8'h00 |=> ext_oe == $past(dir_x))
    else $error("enables wrong after mask write");
  chk_oe_hold: assert property (pready && !(wr && paddr == 8'h00) |=> $stable(ext_oe))
    else $error("enables moved without mask write");
  chk_point_cmd: assert property (cmd && is_x && ext_oe[xi] |=> ext_out[$past(xi)] == $past(bv))
    else $error("extended point command wrong");
  chk_main_cmd: assert property (cmd && pt >= 8'h01 && pt <= 8'h08
    |=> main_out[$past(pt[2:0]) - 3'h1] == $past(bv)) else $error("main point command wrong");
  chk_input_skip: assert property (cmd && is_x && !ext_oe[xi] |=> $stable(ext_out))
    else $error("input group point changed");
  chk_go_none: assert property (wr && paddr == 8'h1C && pwdata[4:1] == 4'h0
    |=> $stable(ext_out)) else $error("omitted fields changed");
  chk_out_hold: assert property (pready && !wr |=> $stable(ext_out) && $stable(main_out))
    else $error("outputs changed without write");
  chk_bad_addr: assert property (psel && !penable && (paddr > 8'h30 || paddr[1:0] != 2'h0)
    |=> pslverr) else $error("no error on unmapped address");
endmodule // exio_port_props
bind exio_port exio_port_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
  .paddr, .pwdata, .pslverr, .main_out, .ext_out, .ext_oe);

/* test/exio_pins_model.sv */
// far-side lines of the extended i/o connector
`timescale 1ns/10ps
module exio_pins_model (
  input wire [63:0]  ext_out,
  input wire [63:0]  ext_oe,
  input wire [63:0]  far_lvl,
  input wire [7:0]   far_main,
  output wire [7:0]  main_in,
  output wire [63:0] ext_in
);
  // far side drives only lines the port leaves undriven
  assign ext_in = (ext_oe & ext_out) | (~ext_oe & far_lvl);
  assign main_in = far_main;
endmodule // exio_pins_model

/* test/extended_io_block_port_tb_top.sv */
// self-checking bench for the extended i/o port
`timescale 1ns/10ps
module extended_io_block_port_tb_top;
  logic        pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, err, v, b;
  logic [1:0]  k;
  logic [7:0]  paddr, main_in, main_out, far_main, m_dir, m_main, p;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] ext_in, ext_out, ext_oe, far_lvl, m_out, lv, o;
  logic [15:0] f [4];
  int          error_cnt, num_checks, r;
  exio_port dut (.pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .main_in, .main_out, .ext_in, .ext_out, .ext_oe);
  exio_pins_model u_pins (.ext_out, .ext_oe, .far_lvl, .far_main, .main_in, .ext_in);
  function automatic logic [63:0] oe_of(input logic [7:0] d);
    for (int g = 0; g < 8; g++)
      oe_of[8*g +: 8] = {8{d[g]}};
  endfunction
  task automatic chk(input logic [63:0] e, input logic [63:0] g, input string n);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic cmp_all;
    o = oe_of(m_dir);
    lv = (o & m_out) | (~o & far_lvl);
    chk(o, ext_oe, "ext_oe");
    chk(m_out, ext_out, "ext_out");
    chk({56'h0, m_main}, {56'h0, main_out}, "main_out");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    repeat (30000) @(posedge pclk);
    error_cnt++;
    tally_and_finish;
  end
  initial
  begin
    {presetn, por_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {m_dir, m_main, m_out} = '0;
    error_cnt = 0;
    num_checks = 0;
    r = $urandom(32'h8C62417D);
    far_lvl = {$urandom, $urandom};
    far_main = 8'($urandom);
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    por_n <= 1'h1;
    apb(1'h0, 8'h00, 32'h0);
    chk(64'h0, rd, "dir");
    apb(1'h1, 8'h00, 32'hC);
    chk(64'h0000_0000_FFFF_0000, ext_oe, "oe12");
    for (int i = 0; i < 60; i++)
    begin
      if (i % 10 == 0)
      begin
        m_dir = 8'($urandom);
        apb(1'h1, 8'h00, {24'h0, m_dir});
      end
      r = $urandom_range(0, 71);
      p = 8'(r < 8 ? r + 1 : r + 9);
      k = 2'($urandom_range(0, 2));
      v = 1'($urandom);
      apb(1'h1, 8'h04, {15'h0, v, 6'h0, k, p});
      b = (k == 2'h2) ? v : ~k[0];
      if (p < 8'h09)
        m_main[p - 8'h01] = b;
      else if (m_dir[(p - 8'h11) >> 3])
        m_out[p - 8'h11] = b;
      cmp_all;
    end
    for (int i = 0; i < 8; i++)
    begin
      m_dir = 8'($urandom);
      apb(1'h1, 8'h00, {24'h0, m_dir});
      o = oe_of(m_dir);
      r = (i == 0) ? 17 : (i == 1) ? 1 : $urandom_range(0, 31);
      p = 8'($urandom);
      apb(1'h1, 8'h08, {24'($urandom), p});
      for (int j = 0; j < 4; j++)
      begin
        f[j] = 16'($urandom);
        apb(1'h1, 8'(8'h0C + 4 * j), {16'($urandom), f[j]});
        if (r[j + 1])
          m_out[16*j +: 16] = (m_out[16*j +: 16] & ~o[16*j +: 16]) | (f[j] & o[16*j +: 16]);
      end
      if (r[0])
        m_main = p;
      apb(1'h1, 8'h1C, r);
      cmp_all;
    end
    far_lvl <= {$urandom, $urandom};
    far_main <= 8'($urandom);
    for (int g = 0; g < 10; g++)
    begin
      apb(1'h1, 8'h24, g);
      apb(1'h0, 8'h28, 32'h0);
      cmp_all;
      chk(g == 0 ? far_main : g == 1 ? 8'h0 : lv[8*(g-2) +: 8], rd, "grp");
    end
    for (int i = 0; i < 24; i++)
    begin
      r = $urandom_range(0, 71);
      apb(1'h1, 8'h2C, r < 8 ? r + 1 : r + 9);
      apb(1'h0, 8'h2C, 32'h0);
      chk(r < 8 ? far_main[r] : lv[r - 8], rd[16], "point");
    end
    apb(1'h0, 8'h40, 32'h0);
    chk(64'h1, err, "slverr");
    apb(1'h1, 8'h20, 32'h1);
    apb(1'h1, 8'h00, 32'h0);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 8'h00, 32'h0);
    chk({56'h0, m_dir}, rd, "dir_reload");
    apb(1'h0, 8'h30, 32'h0);
    cmp_all;
    chk(64'h1, rd[0], "nv_valid");
    por_n <= 1'h0;
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    por_n <= 1'h1;
    presetn <= 1'h1;
    apb(1'h0, 8'h30, 32'h0);
    {m_dir, m_main, m_out} = '0;
    cmp_all;
    chk(64'h0, rd[0], "nv_valid");
    tally_and_finish;
  end
endmodule // extended_io_block_port_tb_top
